// *** src/bsd_pkg.sv ***
// bsd_pkg: constants for the boot section address decoder
// assumes a 16-bit flash byte pointer and a two-bit boot-size fuse field
package bsd_pkg;
    localparam int PTR_W = 16;
    localparam int PC_W  = 13;
    localparam int prog_counter_top_bit      = 12;
    localparam int page_word_top_bit         = 5;
    localparam int pointer_counter_top_bit   = 13;
    localparam int pointer_page_word_top_bit = 6;
    localparam int PAGE_WORDS = 64;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_NUM_W = 7;
    localparam int WORD_SEL_W = 6;
    // boot-area starts, indexed by fuse code, 16 KB and 8 KB parts
    localparam logic [15:0] BOOT16_CODE3 = 16'h3E00;
    localparam logic [15:0] BOOT16_CODE2 = 16'h3C00;
    localparam logic [15:0] BOOT16_CODE1 = 16'h3800;
    localparam logic [15:0] BOOT16_CODE0 = 16'h3000;
    localparam logic [15:0] BOOT8_CODE3  = 16'h1E00;
    localparam logic [15:0] BOOT8_CODE2  = 16'h1C00;
    localparam logic [15:0] BOOT8_CODE1  = 16'h1800;
    localparam logic [15:0] BOOT8_CODE0  = 16'h1000;
    localparam logic [15:0] FLASH16_END  = 16'h3FFF;
    localparam logic [15:0] FLASH8_END   = 16'h1FFF;
    localparam logic [15:0] RDWR16_END   = 16'h2FFF;
    localparam logic [15:0] RDWR8_END    = 16'h0FFF;
    localparam logic [15:0] PTR_RESET    = 16'h0000;
    localparam logic [1:0]  FUSE_RESET   = 2'h3;
endpackage : bsd_pkg

// *** src/bsd_boot_map.sv ***
// bsd_boot_map: combinational fuse code to boot boundary lookup
// assumes fuse bits arrive already inverted-sense (programmed reads zero)
module bsd_boot_map
    import bsd_pkg::*;
(
    // selection
    input  wire logic        part_is_16k,
    input  wire logic [1:0]  boot_size_select,
    // result
    output logic [15:0] boot_start,
    output logic [15:0] flash_end
);
    always_comb begin
        flash_end = part_is_16k ? FLASH16_END : FLASH8_END;
        case ({part_is_16k, boot_size_select})
            3'h7:    boot_start = BOOT16_CODE3; // R1
            3'h6:    boot_start = BOOT16_CODE2; // R1
            3'h5:    boot_start = BOOT16_CODE1; // R1
            3'h4:    boot_start = BOOT16_CODE0; // R1
            3'h3:    boot_start = BOOT8_CODE3; // R2
            3'h2:    boot_start = BOOT8_CODE2; // R2
            3'h1:    boot_start = BOOT8_CODE1; // R2
            default: boot_start = BOOT8_CODE0; // R2
        endcase
    end
endmodule : bsd_boot_map

// *** src/bsd_decoder.sv ***
// bsd_decoder: flash partition classifier and pointer field splitter
// assumes the core presents the byte pointer and fuse bits in sys_clk domain
// Function
// R1: 16 KB part: fuse codes 11..00 give boot start 0x3E00..0x3000, end 0x3FFF.
// R2: 8 KB part: codes give boot start 0x1E00..0x1000; application ends below.
// R3: read-while-write up to 0x2FFF (16 KB) or 0x0FFF (8 KB).
// R4: a page holds 64 words, 128 bytes.
// R5: program counter is 13 bits, top bit 12.
// R6: word within page uses program-counter bits 5 to 0.
// R7: pointer bit 13 maps to program-counter top bit.
// R8: pointer bit 6 maps to top word-in-page bit.
// R9: page number taken from pointer bits 13 down to 7.
// R10: buffer word taken from pointer bits 6 down to 1.
// R11: software keeps word-select bits zero during page write.
// R12: software keeps pointer bit zero clear for store commands.
// R13: pointer bit zero picks low or high byte on loads.
// R14: programmed fuse reads zero, unprogrammed reads one.
// R15: each address classified as application or boot, read-while-write or not.
module bsd_decoder
    import bsd_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // configuration
    input  wire logic                  part_is_16k,
    input  wire logic                  boot_size_sel_hi,
    input  wire logic                  boot_size_sel_lo,
    // pointer and access kind
    input  wire logic [PTR_W-1:0]      flash_ptr,
    input  wire logic                  page_write_req,
    input  wire logic                  flash_store_req,
    // decoded outputs
    output logic [PAGE_NUM_W-1:0]      page_select_field,
    output logic [WORD_SEL_W-1:0]      word_select_field,
    output logic [PC_W-1:0]            word_addr,
    output logic                       high_byte_sel,
    output logic                       in_boot_area,
    output logic                       in_app_area,
    output logic                       read_while_write_region,
    output logic                       no_read_while_write_region,
    output logic                       addr_in_range,
    output logic [15:0]                boot_reset_addr,
    output logic [15:0]                app_end_addr,
    output logic [1:0]                 boot_size_select,
    output logic                       page_write_misuse,
    output logic                       store_odd_ptr
);
    logic [15:0] boot_start;
    logic [15:0] flash_end;
    logic [1:0]  fuse_now;
    logic [15:0] rdwr_end;

    // shared decode, used by more than one register
    function automatic logic [WORD_SEL_W-1:0] word_of(
        input logic [PTR_W-1:0] ptr
    );
        return ptr[pointer_page_word_top_bit:1];
    endfunction : word_of

    function automatic logic in_span(
        input logic [PTR_W-1:0] ptr,
        input logic [PTR_W-1:0] lo,
        input logic [PTR_W-1:0] hi
    );
        return (ptr >= lo) && (ptr <= hi);
    endfunction : in_span

    // last application byte, one below the boot start
    function automatic logic [15:0] last_below(
        input logic [15:0] start
    );
        return start - 16'h0001;
    endfunction : last_below

    // fuse pins already follow programmed-equals-zero sense
    assign fuse_now = {boot_size_sel_hi, boot_size_sel_lo}; // R14
    assign rdwr_end = part_is_16k ? RDWR16_END : RDWR8_END; // R3

    bsd_boot_map u_map (
        .part_is_16k      (part_is_16k),
        .boot_size_select (fuse_now),
        .boot_start       (boot_start),
        .flash_end        (flash_end)
    );

    // outputs registered to keep every output flop-driven
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            page_select_field <= '0;
            word_select_field <= '0;
            word_addr         <= '0;
            high_byte_sel     <= 1'b0;
        end else begin
            // R7 R9
            page_select_field <=
                flash_ptr[pointer_counter_top_bit:PAGE_NUM_W];
            // R8 R10 R6 R4
            word_select_field <= word_of(flash_ptr);
            word_addr <= flash_ptr[prog_counter_top_bit+1:1]; // R5
            high_byte_sel <= flash_ptr[0]; // R13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_boot_area               <= 1'b0;
            in_app_area                <= 1'b1;
            read_while_write_region    <= 1'b1;
            no_read_while_write_region <= 1'b0;
            addr_in_range              <= 1'b1;
            boot_reset_addr            <= BOOT16_CODE3;
            app_end_addr               <= last_below(BOOT16_CODE3);
            boot_size_select           <= FUSE_RESET;
        end else begin
            // R15 R1 R2
            in_boot_area <= in_span(flash_ptr, boot_start, flash_end);
            in_app_area  <= flash_ptr < boot_start;
            // R3 R15
            read_while_write_region    <= flash_ptr <= rdwr_end;
            no_read_while_write_region <= (flash_ptr > rdwr_end)
                                          && (flash_ptr <= flash_end);
            addr_in_range   <= in_span(flash_ptr, 16'h0000, flash_end);
            boot_reset_addr <= boot_start; // R1 R2
            app_end_addr    <= last_below(boot_start); // R2
            boot_size_select <= fuse_now;
        end
    end

    // flags of software misuse, the block does not enforce them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            page_write_misuse <= 1'b0;
            store_odd_ptr     <= 1'b0;
        end else begin
            page_write_misuse <= page_write_req
                && (word_of(flash_ptr) != '0); // R11
            store_odd_ptr <= flash_store_req && flash_ptr[0]; // R12
        end
    end

    chk_boot_start_top: assert property ( // R1
        @(posedge sys_clk) disable iff (srst)
        (part_is_16k && fuse_now == 2'h0) |=> boot_reset_addr == 16'h3000)
        else $error("boot start wrong for 16k code 00");
    chk_boot8_start: assert property ( // R2
        @(posedge sys_clk) disable iff (srst)
        (!part_is_16k && fuse_now == 2'h3) |=> (boot_reset_addr == 16'h1E00
            && app_end_addr == 16'h1DFF))
        else $error("boot start wrong for 8k code 11");
    chk_region_limit: assert property ( // R3
        @(posedge sys_clk) disable iff (srst)
        (part_is_16k && flash_ptr == 16'h3000) |=>
            (no_read_while_write_region && !read_while_write_region))
        else $error("read-while-write limit wrong");
    chk_page_field: assert property ( // R9
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> page_select_field == $past(flash_ptr[13:7]))
        else $error("page field wrong");
    chk_word_field: assert property ( // R10
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> word_select_field == $past(flash_ptr[6:1]))
        else $error("word field wrong");
    chk_word_addr: assert property ( // R5
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> word_addr[12] == $past(flash_ptr[13]))
        else $error("word address top bit wrong");
    chk_byte_sel: assert property ( // R13
        @(posedge sys_clk) disable iff (srst)
        $rose(flash_ptr[0]) |=> high_byte_sel)
        else $error("byte select not following pointer");
    chk_area_split: assert property ( // R15
        @(posedge sys_clk) disable iff (srst)
        addr_in_range |-> (in_boot_area != in_app_area))
        else $error("address in both or neither area");
    chk_boot_area_top: assert property ( // R1
        @(posedge sys_clk) disable iff (srst)
        (part_is_16k && flash_ptr >= 16'h3E00 && flash_ptr <= 16'h3FFF)
            |=> (in_boot_area && !in_app_area))
        else $error("top boot page not in boot area");
    chk_app_end_top: assert property ( // R1
        @(posedge sys_clk) disable iff (srst)
        (part_is_16k && fuse_now == 2'h3) |=> (boot_reset_addr == 16'h3E00
            && app_end_addr == 16'h3DFF))
        else $error("boot start wrong for 16k code 11");
    chk_boot8_low: assert property ( // R2
        @(posedge sys_clk) disable iff (srst)
        (!part_is_16k && fuse_now == 2'h0) |=> (boot_reset_addr == 16'h1000
            && app_end_addr == 16'h0FFF))
        else $error("boot start wrong for 8k code 00");
    chk_small_limit: assert property ( // R3
        @(posedge sys_clk) disable iff (srst)
        (!part_is_16k && flash_ptr == 16'h0FFF) |=>
            (read_while_write_region && !no_read_while_write_region))
        else $error("read-while-write limit wrong on 8k part");
    chk_region_split: assert property ( // R3
        @(posedge sys_clk) disable iff (srst)
        addr_in_range |-> (read_while_write_region
            != no_read_while_write_region))
        else $error("address in both or neither write region");
    chk_page_bytes: assert property ( // R4
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> {page_select_field, word_select_field, high_byte_sel}
            == $past(flash_ptr[13:0]))
        else $error("page, word and byte fields do not tile");
    chk_word_addr_full: assert property ( // R5
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> word_addr == $past(flash_ptr[13:1]))
        else $error("word address wrong");
    chk_word_top: assert property ( // R6 R8
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> word_select_field[5] == $past(flash_ptr[6]))
        else $error("word field top bit wrong");
    chk_page_top: assert property ( // R7
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> page_select_field[6] == $past(flash_ptr[13]))
        else $error("page field top bit wrong");
    chk_fuse_copy: assert property ( // R14
        @(posedge sys_clk) disable iff (srst)
        1'b1 |=> boot_size_select
            == $past({boot_size_sel_hi, boot_size_sel_lo}))
        else $error("fuse copy wrong");
    chk_write_misuse: assert property ( // R11
        @(posedge sys_clk) disable iff (srst)
        (page_write_req && flash_ptr[6:1] != 6'h00) |=> page_write_misuse)
        else $error("page write misuse not flagged");
    chk_store_odd: assert property ( // R12
        @(posedge sys_clk) disable iff (srst)
        (flash_store_req && flash_ptr[0]) |=> store_odd_ptr)
        else $error("odd store pointer not flagged");
    chk_load_quiet: assert property ( // R12
        @(posedge sys_clk) disable iff (srst)
        !flash_store_req |=> !store_odd_ptr)
        else $error("odd store flag without a store");
    chk_beyond_end: assert property ( // R15
        @(posedge sys_clk) disable iff (srst)
        !addr_in_range |-> !(in_boot_area || in_app_area
            || read_while_write_region || no_read_while_write_region))
        else $error("region flag set beyond flash end");
endmodule : bsd_decoder

// *** testbench/bsd_core_model.sv ***
// bsd_core_model: core side issuing flash loads, stores and page writes
// assumes the bench sets the wanted op at least one edge before use
module bsd_core_model
    import bsd_pkg::*;
(
    // request from bench
    input  wire logic             sys_clk,
    input  wire logic [PTR_W-1:0] want_ptr,
    input  wire logic [1:0]       want_op,
    input  wire logic             break_rules,
    // to decoder
    output logic [PTR_W-1:0]      flash_ptr,
    output logic                  page_write_req,
    output logic                  flash_store_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // op 0 load, 1 buffer fill, 2 page write; misuse only on command
    function automatic logic [PTR_W-1:0] shaped(
        input logic [PTR_W-1:0] p,
        input logic [1:0]       op,
        input logic             brk
    );
        logic [PTR_W-1:0] r;
        r = p;
        if (op == 2'h2 && !brk) r[6:1] = 6'h00;
        if (op != 2'h0 && !brk) r[0] = 1'b0;
        return r;
    endfunction : shaped
    // one assignment per signal per edge, so the decoder sees no glitch
    always @(posedge sys_clk) begin
        #1;
        flash_ptr = shaped(want_ptr, want_op, break_rules);
        page_write_req = (want_op == 2'h2);
        flash_store_req = (want_op != 2'h0);
    end
endmodule : bsd_core_model

// *** testbench/bsd_decoder_tb.sv ***
// bsd_decoder_tb: self-checking bench for the boot section decoder
// assumes outputs follow sampled inputs by one sys_clk edge
module bsd_decoder_tb
    import bsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, srst = 1'b1, part_is_16k = 1'b0;
    logic boot_size_sel_hi = 1'b0, boot_size_sel_lo = 1'b0;
    logic [15:0] want_ptr = 16'h0000, flash_ptr, boot_reset_addr, app_end_addr;
    logic [1:0] want_op = 2'h0, boot_size_select;
    logic break_rules = 1'b0, page_write_req, flash_store_req, high_byte_sel;
    logic in_boot_area, in_app_area, read_while_write_region, addr_in_range;
    logic no_read_while_write_region, page_write_misuse, store_odd_ptr;
    logic [6:0] page_select_field;
    logic [5:0] word_select_field;
    logic [12:0] word_addr;
    int failures = 0, n_compared = 0, cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    bsd_core_model u_core (.sys_clk, .want_ptr, .want_op, .break_rules,
        .flash_ptr, .page_write_req, .flash_store_req);
    bsd_decoder u_dut (.sys_clk, .srst, .part_is_16k, .boot_size_sel_hi,
        .boot_size_sel_lo, .flash_ptr, .page_write_req, .flash_store_req,
        .page_select_field, .word_select_field, .word_addr, .high_byte_sel,
        .in_boot_area, .in_app_area, .read_while_write_region,
        .no_read_while_write_region, .addr_in_range, .boot_reset_addr,
        .app_end_addr, .boot_size_select, .page_write_misuse, .store_odd_ptr);
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // model drives one edge later, decoder answers one edge after that
    task automatic apply(input logic [15:0] p, input logic [1:0] op,
                         input logic brk);
        want_ptr = p;
        want_op = op;
        break_rules = brk;
        repeat (3) @(posedge sys_clk);
        #2;
    endtask : apply
    task automatic t_map;
        logic [15:0] st;
        for (int i = 0; i < 8; i++) begin
            part_is_16k = i[2];
            {boot_size_sel_hi, boot_size_sel_lo} = i[1:0];
            st = (i[2] ? 16'h4000 : 16'h2000) - (16'h0200 << (3 - i[1:0]));
            apply(st, 2'h0, 1'b0);
            check("boot_reset_addr", boot_reset_addr, st);
            check("app_end_addr", app_end_addr, st - 16'h0001);
            check("boot_size_select", boot_size_select, i[1:0]);
            check("in_boot_area", in_boot_area, 1'b1);
            apply(st - 16'h0001, 2'h0, 1'b0);
            check("in_app_area", in_app_area, 1'b1);
            check("in_boot_area", in_boot_area, 1'b0);
        end
        $display("t_map done");
    endtask : t_map
    task automatic t_rww;
        logic [15:0] e;
        for (int p = 0; p < 2; p++) begin
            part_is_16k = p[0];
            e = p[0] ? 16'h2FFF : 16'h0FFF;
            apply(e, 2'h0, 1'b0);
            check("rw_region", read_while_write_region, 1'b1);
            apply(e + 16'h0001, 2'h0, 1'b0);
            check("rw_region", read_while_write_region, 1'b0);
            check("no_rw_region", no_read_while_write_region, 1'b1);
            apply(e + 16'h1001, 2'h0, 1'b0);
            check("addr_in_range", addr_in_range, 1'b0);
            check("no_rw_region", no_read_while_write_region, 1'b0);
        end
        $display("t_rww done");
    endtask : t_rww
    task automatic t_fields;
        logic [15:0] ps [2] = '{16'h3E02, 16'h2AFF};
        foreach (ps[k]) begin
            apply(ps[k], 2'h0, 1'b0);
            check("page", page_select_field, ps[k][13:7]);
            check("word", word_select_field, ps[k][6:1]);
            check("word_addr", word_addr, ps[k][13:1]);
            check("high_byte_sel", high_byte_sel, ps[k][0]);
        end
        $display("t_fields done");
    endtask : t_fields
    task automatic t_misuse;
        apply(16'h1235, 2'h2, 1'b0);
        check("page_write_misuse", page_write_misuse, 1'b0);
        apply(16'h1235, 2'h2, 1'b1);
        check("page_write_misuse", page_write_misuse, 1'b1);
        apply(16'h1235, 2'h1, 1'b1);
        check("store_odd_ptr", store_odd_ptr, 1'b1);
        apply(16'h1235, 2'h1, 1'b0);
        check("store_odd_ptr", store_odd_ptr, 1'b0);
        $display("t_misuse done");
    endtask : t_misuse
    task automatic end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 600) begin
            failures++;
            end_of_test;
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        #2;
        check("reset boot_size_select", boot_size_select, 2'h3);
        check("reset boot_reset_addr", boot_reset_addr, 16'h3E00);
        check("reset in_app_area", in_app_area, 1'b1);
        srst = 1'b0;
        t_map;
        t_rww;
        t_fields;
        t_misuse;
        end_of_test;
    end
endmodule : bsd_decoder_tb
